/* File: core/cmb_pkg.sv */
// Shared constants and types for the CAN message buffering block.
package cmb_pkg;
  // Storage sizes.
  localparam int CMB_NTX = 3;
  localparam logic [3:0] CMB_MSG_BYTES = 4'hd;
  localparam logic [3:0] CMB_LOCAL_PRIORITY_FIELD_IDX = 4'hd;
  localparam logic [3:0] CMB_TSH_IDX = 4'he;
  localparam logic [3:0] CMB_TSL_IDX = 4'hf;
  localparam logic [3:0] CMB_RXTSH_IDX = 4'hd;
  localparam logic [3:0] CMB_RXTSL_IDX = 4'he;
  localparam logic [3:0] CMB_RX_LAST = 4'he;
  localparam logic [2:0] CMB_FIFO_DEPTH = 3'h5;
  localparam logic [2:0] CMB_FIFO_LAST = 3'h4;
  // Device register port pages and register addresses.
  localparam logic [1:0] CMB_PG_RX = 2'h0;
  localparam logic [1:0] CMB_PG_TX = 2'h1;
  localparam logic [5:0] CMB_A_TXFLG = 6'h20;
  localparam logic [5:0] CMB_A_ABORT = 6'h21;
  localparam logic [5:0] CMB_A_ACK = 6'h22;
  localparam logic [5:0] CMB_A_SEL = 6'h23;
  localparam logic [5:0] CMB_A_RXFLG = 6'h24;
  localparam logic [5:0] CMB_A_CTL = 6'h25;
  // Receive flag and control field positions.
  localparam int CMB_RXF_BIT = 0;
  localparam int CMB_OVR_BIT = 1;
  localparam int CMB_LOOP_BIT = 0;
  localparam int CMB_TXIE_BIT = 1;
  localparam int CMB_RXIE_BIT = 2;
  localparam int CMB_OVIE_BIT = 3;
  localparam int CMB_TSEN_BIT = 4;
  // Reset values.
  localparam logic [2:0] CMB_TXEMPTY_RST = 3'h7;
  localparam logic [7:0] CMB_CTL_RST = 8'h00;
  // Host APB register offsets.
  localparam logic [11:0] CMB_P_CMD = 12'h000;
  localparam logic [11:0] CMB_P_STAT = 12'h004;
  localparam logic [11:0] CMB_P_CTL = 12'h008;
  localparam logic [5:0] CMB_P_STAGE_PG = 6'h01;
  // Host commands.
  typedef enum logic [1:0] {
    CMB_OP_NONE = 2'b00,
    CMB_OP_SEND = 2'b01,
    CMB_OP_ABORT = 2'b10,
    CMB_OP_RECV = 2'b11
  } cmb_op_e;
  // Host sequencer states.
  typedef enum logic [2:0] {
    CMB_H_IDLE = 3'b000,
    CMB_H_FLAGS = 3'b001,
    CMB_H_WAITF = 3'b010,
    CMB_H_SEL = 3'b011,
    CMB_H_LOAD = 3'b100,
    CMB_H_READY = 3'b101,
    CMB_H_RECV = 3'b110,
    CMB_H_RCLR = 3'b111
  } cmb_hst_e;
  // Next slot of the five-entry receive ring.
  function automatic logic [2:0] cmb_inc5(input logic [2:0] p);
    return (p == CMB_FIFO_LAST) ? 3'h0 : p + 3'h1;
  endfunction
endpackage

/* File: core/cmb_if.sv */
// Byte-wide register port between the host controller and the buffering device.
`timescale 1ns/1ns
`default_nettype none
interface cmb_if;
  logic [5:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic tx_irq;
  logic rx_irq;
  logic err_irq;
  modport dev(input addr, wr, rd, wdata, output rdata, rvalid, tx_irq, rx_irq, err_irq);
  modport host(output addr, wr, rd, wdata, input rdata, rvalid, tx_irq, rx_irq, err_irq);
endinterface
`default_nettype wire

/* File: core/cmb_local_priority_field_sel.sv */
// Local priority selection among the ready transmit buffers.
`timescale 1ns/1ns
`default_nettype none
module cmb_local_priority_field_sel import cmb_pkg::*; (
  // Buffer state.
  input wire logic [CMB_NTX-1:0] ready,
  input wire logic [CMB_NTX-1:0][7:0] local_priority_field,
  // Selection.
  output logic any,
  output logic [1:0] pick
);
  logic [CMB_NTX-1:0] wins;

  // A buffer wins when no other ready buffer beats it; equal values go to the lower index.
  for (genvar i = 0; i < CMB_NTX; i++) begin : g_win
    always_comb begin
      wins[i] = ready[i];
      for (int j = 0; j < CMB_NTX; j++) begin
        if (j < i && ready[j] && local_priority_field[j] <= local_priority_field[i]) begin
          wins[i] = 1'b0;
        end
        if (j > i && ready[j] && local_priority_field[j] < local_priority_field[i]) begin
          wins[i] = 1'b0;
        end
      end
    end
  end

  // Exactly one bit of wins is set when any buffer is ready.
  assign any = |ready;
  assign pick = wins[0] ? 2'h0 : (wins[1] ? 2'h1 : 2'h2);
endmodule
`default_nettype wire

/* File: core/cmb_device.sv */
// CAN message buffering device: triple transmit buffer and five-entry receive FIFO.
`timescale 1ns/1ns
`default_nettype none
module cmb_device import cmb_pkg::*; (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Host register port.
  cmb_if.dev bus,
  // Transmit side of the protocol engine.
  output logic tx_pending,
  output logic [1:0] tx_buf,
  output logic [103:0] tx_msg,
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic tx_fail,
  input wire logic arb_lost,
  input wire logic [15:0] timestamp,
  // Receive side of the protocol engine.
  input wire logic rx_sof,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_accept,
  input wire logic rx_ok,
  input wire logic rx_bad,
  output logic rx_ack_en
);
  typedef struct packed {
    logic [2:0] tx_empty;
    logic [2:0] abort_req;
    logic [2:0] abort_ack;
    logic [1:0] sel;
    logic [CMB_NTX-1:0][15:0][7:0] txb;
    logic busy;
    logic [1:0] cur;
    logic [1:0] pick;
    logic pend;
    logic [12:0][7:0] msg;
    logic [14:0][7:0] bg;
    logic [3:0] bidx;
    logic own;
    logic [4:0][14:0][7:0] fifo;
    logic [2:0] rp;
    logic [2:0] wp;
    logic [2:0] cnt;
    logic ovr;
    logic [7:0] ctl;
    logic [7:0] rdata;
    logic rvalid;
    logic tx_irq;
    logic rx_irq;
    logic err_irq;
    logic ack_en;
  } cmb_dev_s;

  cmb_dev_s s;
  cmb_dev_s n;
  logic any;
  logic [1:0] pick;
  logic [CMB_NTX-1:0][7:0] prios;
  logic push;
  logic pop;

  // Priority field of each buffer feeds the selector.
  for (genvar i = 0; i < CMB_NTX; i++) begin : g_local_priority_field
    assign prios[i] = s.txb[i][CMB_LOCAL_PRIORITY_FIELD_IDX];
  end

  cmb_local_priority_field_sel u_sel (
    .ready(~s.tx_empty),
    .local_priority_field(prios),
    .any(any),
    .pick(pick)
  );

  // Next-state logic for the whole device.
  always_comb begin
    n = s;
    push = 1'b0;
    pop = 1'b0;
    n.rvalid = 1'b0;
    // Host writes; hardware updates below override them so a set is never lost.
    if (bus.wr) begin
      if (bus.addr[5:4] == CMB_PG_TX) begin
        if (s.tx_empty[s.sel] && bus.addr[3:0] <= CMB_LOCAL_PRIORITY_FIELD_IDX) begin
          n.txb[s.sel][bus.addr[3:0]] = bus.wdata;
        end
      end else begin
        case (bus.addr)
          CMB_A_TXFLG: begin
            n.tx_empty = s.tx_empty & ~bus.wdata[2:0];
            n.abort_ack = s.abort_ack & ~bus.wdata[2:0];
          end
          CMB_A_ABORT: n.abort_req = s.abort_req | (bus.wdata[2:0] & ~s.tx_empty);
          CMB_A_SEL: begin
            // The lowest requested buffer that is empty is mapped in.
            if (bus.wdata[0] && s.tx_empty[0]) begin
              n.sel = 2'h0;
            end else if (bus.wdata[1] && s.tx_empty[1]) begin
              n.sel = 2'h1;
            end else if (bus.wdata[2] && s.tx_empty[2]) begin
              n.sel = 2'h2;
            end
          end
          CMB_A_RXFLG: begin
            pop = bus.wdata[CMB_RXF_BIT] && (s.cnt != 3'h0);
            if (bus.wdata[CMB_OVR_BIT]) begin
              n.ovr = 1'b0;
            end
          end
          CMB_A_CTL: n.ctl = bus.wdata;
          default: ;
        endcase
      end
    end
    // Host reads answer one cycle later.
    if (bus.rd) begin
      n.rvalid = 1'b1;
      n.rdata = 8'h00;
      if (bus.addr[5:4] == CMB_PG_RX) begin
        if (s.cnt != 3'h0 && bus.addr[3:0] <= CMB_RX_LAST) begin
          n.rdata = s.fifo[s.rp][bus.addr[3:0]];
        end
      end else if (bus.addr[5:4] == CMB_PG_TX) begin
        n.rdata = s.txb[s.sel][bus.addr[3:0]];
      end else begin
        case (bus.addr)
          CMB_A_TXFLG: n.rdata = {5'h00, s.tx_empty};
          CMB_A_ABORT: n.rdata = {5'h00, s.abort_req};
          CMB_A_ACK: n.rdata = {5'h00, s.abort_ack};
          CMB_A_SEL: n.rdata = 8'h01 << s.sel;
          CMB_A_RXFLG: n.rdata = {6'h00, s.ovr, s.cnt != 3'h0};
          CMB_A_CTL: n.rdata = s.ctl;
          default: n.rdata = 8'h00;
        endcase
      end
    end
    // Selection runs every cycle, so it is fresh just before each start of frame.
    n.pick = pick;
    n.pend = any && !s.busy;
    n.msg = s.txb[pick][12:0];
    if (tx_start && s.pend && !s.tx_empty[s.pick]) begin
      n.busy = 1'b1;
      n.cur = s.pick;
      n.own = 1'b1;
    end
    // Successful send releases the buffer and stamps it.
    if (s.busy && tx_done) begin
      n.busy = 1'b0;
      n.tx_empty[s.cur] = 1'b1;
      n.abort_ack[s.cur] = 1'b0;
      n.abort_req[s.cur] = 1'b0;
      if (s.ctl[CMB_TSEN_BIT]) begin
        n.txb[s.cur][CMB_TSH_IDX] = timestamp[15:8];
        n.txb[s.cur][CMB_TSL_IDX] = timestamp[7:0];
      end
    end
    // An error or lost arbitration leaves the buffer ready for the next round.
    if (s.busy && (tx_fail || arb_lost)) begin
      n.busy = 1'b0;
    end
    if (arb_lost) begin
      n.own = 1'b0;
    end
    // Abort grants skip the buffer that is on the bus.
    for (int i = 0; i < CMB_NTX; i++) begin
      if (s.abort_req[i] && !n.tx_empty[i] && !(n.busy && n.cur == 2'(i))) begin
        n.abort_ack[i] = 1'b1;
        n.tx_empty[i] = 1'b1;
        n.abort_req[i] = 1'b0;
      end
    end
    // Background capture runs for every frame, own frames included.
    if (rx_sof) begin
      n.bidx = 4'h0;
    end
    if (rx_byte_valid && s.bidx < CMB_MSG_BYTES) begin
      n.bg[s.bidx] = rx_byte;
      n.bidx = s.bidx + 4'h1;
    end
    // Only a valid accepted frame that is not our own, or any such frame in loopback, leaves the background buffer.
    if (rx_ok && rx_accept && (!s.own || s.ctl[CMB_LOOP_BIT])) begin
      if (s.cnt == CMB_FIFO_DEPTH && !pop) begin
        n.ovr = 1'b1;
      end else begin
        push = 1'b1;
        n.fifo[s.wp] = s.bg;
        if (s.ctl[CMB_TSEN_BIT]) begin
          n.fifo[s.wp][CMB_RXTSH_IDX] = timestamp[15:8];
          n.fifo[s.wp][CMB_RXTSL_IDX] = timestamp[7:0];
        end
        n.wp = cmb_inc5(s.wp);
      end
    end
    if (rx_ok || rx_bad) begin
      n.own = 1'b0;
    end
    // Ring bookkeeping.
    if (pop) begin
      n.rp = cmb_inc5(s.rp);
    end
    if (push && !pop) begin
      n.cnt = s.cnt + 3'h1;
    end else if (pop && !push) begin
      n.cnt = s.cnt - 3'h1;
    end
    // Interrupt levels gated by their enables.
    n.tx_irq = n.ctl[CMB_TXIE_BIT] && (|n.tx_empty);
    n.rx_irq = n.ctl[CMB_RXIE_BIT] && (n.cnt != 3'h0);
    n.err_irq = n.ctl[CMB_OVIE_BIT] && n.ovr;
    n.ack_en = !(n.own && !n.ctl[CMB_LOOP_BIT]);
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.tx_empty <= CMB_TXEMPTY_RST;
      s.ctl <= CMB_CTL_RST;
      s.ack_en <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  // Outputs come straight from the state register.
  assign bus.rdata = s.rdata;
  assign bus.rvalid = s.rvalid;
  assign bus.tx_irq = s.tx_irq;
  assign bus.rx_irq = s.rx_irq;
  assign bus.err_irq = s.err_irq;
  assign tx_pending = s.pend;
  assign tx_buf = s.pick;
  assign tx_msg = s.msg;
  assign rx_ack_en = s.ack_en;
endmodule
`default_nettype wire

/* File: core/cmb_host.sv */
// Host controller: APB command registers driving the buffering device's register port.
`timescale 1ns/1ns
`default_nettype none
module cmb_host import cmb_pkg::*; (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device register port.
  cmb_if.host dev
);
  typedef struct packed {
    cmb_hst_e st;
    logic send;
    logic [13:0][7:0] stage;
    logic [14:0][7:0] rxs;
    logic [3:0] idx;
    logic [1:0] bsel;
    logic wait_rd;
    logic nobuf;
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cmb_hst_s;

  cmb_hst_s s;
  cmb_hst_s n;
  logic stage_hit;
  logic hit;
  logic [3:0] sidx;

  // APB address decode.
  assign sidx = paddr[5:2];
  assign stage_hit = (paddr[11:6] == CMB_P_STAGE_PG) && (paddr[1:0] == 2'h0);
  assign hit = (paddr == CMB_P_CMD) || (paddr == CMB_P_STAT) || (paddr == CMB_P_CTL) ||
               stage_hit;

  // Sequencer and APB slave next state.
  always_comb begin
    n = s;
    n.wr = 1'b0;
    n.rd = 1'b0;
    unique case (s.st)
      CMB_H_IDLE: ;
      CMB_H_FLAGS: begin
        n.rd = 1'b1;
        n.addr = s.send ? CMB_A_TXFLG : CMB_A_RXFLG;
        n.st = CMB_H_WAITF;
      end
      CMB_H_WAITF: begin
        if (dev.rvalid) begin
          n.st = CMB_H_SEL;
          n.idx = 4'h0;
          n.wait_rd = 1'b0;
          if (!s.send) begin
            n.st = dev.rdata[CMB_RXF_BIT] ? CMB_H_RECV : CMB_H_IDLE;
            n.nobuf = !dev.rdata[CMB_RXF_BIT];
          end else if (dev.rdata[0]) begin
            n.bsel = 2'h0;
          end else if (dev.rdata[1]) begin
            n.bsel = 2'h1;
          end else if (dev.rdata[2]) begin
            n.bsel = 2'h2;
          end else begin
            n.nobuf = 1'b1;
            n.st = CMB_H_IDLE;
          end
        end
      end
      CMB_H_SEL: begin
        n.wr = 1'b1;
        n.addr = CMB_A_SEL;
        n.wdata = 8'h01 << s.bsel;
        n.st = CMB_H_LOAD;
      end
      CMB_H_LOAD: begin
        n.wr = 1'b1;
        n.addr = {CMB_PG_TX, s.idx};
        n.wdata = s.stage[s.idx];
        n.idx = s.idx + 4'h1;
        if (s.idx == CMB_LOCAL_PRIORITY_FIELD_IDX) begin
          n.st = CMB_H_READY;
        end
      end
      CMB_H_READY: begin
        n.wr = 1'b1;
        n.addr = CMB_A_TXFLG;
        n.wdata = 8'h01 << s.bsel;
        n.st = CMB_H_IDLE;
      end
      CMB_H_RECV: begin
        if (!s.wait_rd) begin
          n.rd = 1'b1;
          n.addr = {CMB_PG_RX, s.idx};
          n.wait_rd = 1'b1;
        end else if (dev.rvalid) begin
          n.rxs[s.idx] = dev.rdata;
          n.wait_rd = 1'b0;
          n.idx = s.idx + 4'h1;
          if (s.idx == CMB_RX_LAST) begin
            n.st = CMB_H_RCLR;
          end
        end
      end
      CMB_H_RCLR: begin
        n.wr = 1'b1;
        n.addr = CMB_A_RXFLG;
        n.wdata = 8'h01 << CMB_RXF_BIT;
        n.st = CMB_H_IDLE;
      end
    endcase
    // First access cycle prepares the answer; the second completes the transfer.
    if (psel && penable && !s.pready) begin
      n.pready = 1'b1;
      n.pslverr = !hit;
      n.prdata = 32'h0000_0000;
      if (paddr == CMB_P_STAT) begin
        n.prdata = {22'h00_0000, s.bsel, 3'h0, dev.err_irq, dev.rx_irq, dev.tx_irq,
                    s.nobuf, s.st != CMB_H_IDLE};
      end else if (stage_hit && sidx <= CMB_RX_LAST) begin
        n.prdata = {24'h00_0000, s.rxs[sidx]};
      end
    end else if (psel && penable) begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (pwrite && stage_hit && sidx <= CMB_LOCAL_PRIORITY_FIELD_IDX) begin
        n.stage[sidx] = pwdata[7:0];
      end
      if (pwrite && paddr == CMB_P_CMD && s.st == CMB_H_IDLE) begin
        unique case (cmb_op_e'(pwdata[1:0]))
          CMB_OP_NONE: ;
          CMB_OP_SEND: begin
            n.st = CMB_H_FLAGS;
            n.send = 1'b1;
            n.nobuf = 1'b0;
          end
          CMB_OP_ABORT: begin
            n.wr = 1'b1;
            n.addr = CMB_A_ABORT;
            n.wdata = {5'h00, pwdata[10:8]};
          end
          CMB_OP_RECV: begin
            n.st = CMB_H_FLAGS;
            n.send = 1'b0;
            n.nobuf = 1'b0;
          end
        endcase
      end
      // Control writes pass straight through to the device while the sequencer is idle.
      if (pwrite && paddr == CMB_P_CTL && s.st == CMB_H_IDLE) begin
        n.wr = 1'b1;
        n.addr = CMB_A_CTL;
        n.wdata = pwdata[7:0];
      end
    end
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  // Outputs come straight from the state register.
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign dev.addr = s.addr;
  assign dev.wr = s.wr;
  assign dev.rd = s.rd;
  assign dev.wdata = s.wdata;
endmodule
`default_nettype wire

/* File: dv/cmb_port_asserts.sv */
// Checker for the register port between the host controller and the buffering device.
`timescale 1ns/1ns
`default_nettype none
module cmb_port_asserts import cmb_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register port signals.
  input wire logic [5:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic err_irq
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ctl_q;
  logic [2:0] flags_q;
  logic [5:0] raddr_q;
  logic [3:0] win_cnt;
  logic [3:0] rx_cnt;
  // Mirrors control writes, the last transmit flag read, the window writes since selection and the receive reads since the flag read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= CMB_CTL_RST;
      flags_q <= 3'h0;
      raddr_q <= 6'h00;
      win_cnt <= 4'h0;
      rx_cnt <= 4'h0;
    end else begin
      if (wr && addr == CMB_A_CTL) ctl_q <= wdata;
      if (rvalid && raddr_q == CMB_A_TXFLG) flags_q <= rdata[2:0];
      if (rd) raddr_q <= addr;
      if (wr && addr == CMB_A_SEL) win_cnt <= 4'h0;
      else if (wr && addr >= 6'h10 && addr <= 6'h1d) win_cnt <= win_cnt + 4'h1;
      if (rd && addr == CMB_A_RXFLG) rx_cnt <= 4'h0;
      else if (rd && addr <= {2'h0, CMB_RX_LAST}) rx_cnt <= rx_cnt + 4'h1;
    end
  end
  property p_rd_answer; rd |=> rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered in the next cycle");
  property p_rvalid_cause; rvalid |-> $past(rd); endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("read data valid without a read");
  property p_sel_empty; wr && addr == CMB_A_SEL |-> (wdata[2:0] & flags_q) != 3'h0; endproperty
  a_sel_empty: assert property (p_sel_empty)
    else $error("selected buffer was not empty");
  property p_load_count; wr && addr == CMB_A_TXFLG |-> win_cnt == 4'he; endproperty
  a_load_count: assert property (p_load_count)
    else $error("buffer marked ready before a full load");
  property p_rx_clear; wr && addr == CMB_A_RXFLG && wdata[CMB_RXF_BIT] |-> rx_cnt == 4'hf;
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("full flag cleared before the message was read");
  property p_tx_mask; tx_irq |-> ctl_q[CMB_TXIE_BIT] || $past(ctl_q[CMB_TXIE_BIT]); endproperty
  a_tx_mask: assert property (p_tx_mask)
    else $error("transmit interrupt while masked");
  property p_rx_mask; rx_irq |-> ctl_q[CMB_RXIE_BIT] || $past(ctl_q[CMB_RXIE_BIT]); endproperty
  a_rx_mask: assert property (p_rx_mask)
    else $error("receive interrupt while masked");
  property p_err_mask; err_irq |-> ctl_q[CMB_OVIE_BIT] || $past(ctl_q[CMB_OVIE_BIT]); endproperty
  a_err_mask: assert property (p_err_mask)
    else $error("overrun interrupt while masked");
  property p_tx_irq_on;
    rvalid && raddr_q == CMB_A_TXFLG && rdata[2:0] != 3'h0 && ctl_q[CMB_TXIE_BIT] |-> ##[0:2] tx_irq;
  endproperty
  a_tx_irq_on: assert property (p_tx_irq_on)
    else $error("empty buffer without transmit interrupt");
  property p_rxf_irq;
    rvalid && raddr_q == CMB_A_RXFLG && rdata[CMB_RXF_BIT] && ctl_q[CMB_RXIE_BIT] |-> ##[0:2] rx_irq;
  endproperty
  a_rxf_irq: assert property (p_rxf_irq)
    else $error("full flag without receive interrupt");
  // Main traffic seen on the port.
  c_select: cover property (wr && addr == CMB_A_SEL);
  c_ready: cover property (wr && addr == CMB_A_TXFLG);
  c_pop: cover property (wr && addr == CMB_A_RXFLG && wdata[CMB_RXF_BIT]);
endmodule
`default_nettype wire

/* File: dv/can_message_buffering_bench.sv */
// Testbench joining host controller and buffering device, driven over APB.
`timescale 1ns/1ns
`default_nettype none
module can_message_buffering_bench import cmb_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, stat;
  logic tx_pending, tx_start, tx_done, tx_fail, arb_lost, rx_ack_en;
  logic [1:0] tx_buf;
  logic [103:0] tx_msg;
  logic rx_sof, rx_byte_valid, rx_accept, rx_ok, rx_bad;
  logic [7:0] rx_byte;
  int failures = 0;
  int tests_run = 0;
  cmb_if bus_if();
  cmb_host u_cmb_host(.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dev(bus_if));
  cmb_device u_cmb_device(.pclk(pclk), .presetn(presetn), .ce(1'b1), .bus(bus_if),
    .tx_pending(tx_pending), .tx_buf(tx_buf), .tx_msg(tx_msg), .tx_start(tx_start),
    .tx_done(tx_done), .tx_fail(tx_fail), .arb_lost(arb_lost), .timestamp(16'h1234),
    .rx_sof(rx_sof), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_accept(rx_accept), .rx_ok(rx_ok), .rx_bad(rx_bad), .rx_ack_en(rx_ack_en));
  cmb_port_asserts u_asserts(.pclk(pclk), .presetn(presetn), .addr(bus_if.addr),
    .wr(bus_if.wr), .rd(bus_if.rd), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .rvalid(bus_if.rvalid), .tx_irq(bus_if.tx_irq), .rx_irq(bus_if.rx_irq),
    .err_irq(bus_if.err_irq));
  // Clock at 250 MHz.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Compares a value and counts the comparison.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic conclude();
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb_xfer(1'b1, a, d, q);
  endtask
  // Polls the status word until the command sequencer is idle.
  task automatic wait_idle();
    do begin
      apb_xfer(1'b0, CMB_P_STAT, 32'h0, stat);
    end while (stat[0] !== 1'b0);
  endtask
  // Stages a message and its priority, then orders it sent.
  task automatic send(input logic [7:0] base, input logic [7:0] local_priority_field);
    for (int i = 0; i < 14; i++) begin
      wr32(12'h040 + 12'(4 * i), (i == 13) ? {24'h0, local_priority_field} : {24'h0, base + 8'(i)});
    end
    wr32(CMB_P_CMD, 32'h1);
    wait_idle();
  endtask
  // Orders a receive and compares the thirteen frame bytes.
  task automatic recv(input logic [7:0] base, input logic none);
    logic [31:0] q;
    wr32(CMB_P_CMD, 32'h3);
    wait_idle();
    check("no message", {31'h0, none}, {31'h0, stat[1]});
    for (int i = 0; i < 13 && !none; i++) begin
      apb_xfer(1'b0, 12'h040 + 12'(4 * i), 32'h0, q);
      check("rx byte", {24'h0, base + 8'(i)}, {24'h0, q[7:0]});
    end
  endtask
  // Pulses transmit engine events {start, done, fail, lost}, then lets them settle.
  task automatic eng(input logic [3:0] ev);
    {tx_start, tx_done, tx_fail, arb_lost} <= ev;
    @(posedge pclk);
    {tx_start, tx_done, tx_fail, arb_lost} <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask
  // Delivers one frame of thirteen bytes with its filter and validity result.
  task automatic frame(input logic [7:0] base, input logic acc, input logic good);
    rx_sof <= 1'b1;
    @(posedge pclk);
    rx_sof <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= base + 8'(i);
      @(posedge pclk);
    end
    rx_byte_valid <= 1'b0;
    rx_accept <= acc;
    rx_ok <= good;
    rx_bad <= !good;
    @(posedge pclk);
    {rx_accept, rx_ok, rx_bad} <= 3'h0;
    @(posedge pclk);
  endtask
  // Watchdog against a hang.
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    conclude();
  end
  // Main sequence.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_start, tx_done, tx_fail, arb_lost} = 4'h0;
    {rx_sof, rx_byte_valid, rx_byte, rx_accept, rx_ok, rx_bad} = '0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Masked interrupts stay low and unmapped addresses are refused; then enable all three.
    apb_xfer(1'b0, CMB_P_STAT, 32'h0, stat);
    check("irq flags", 32'h0, 32'(stat[4:2]));
    check("slave error", 32'h0, 32'(err_q));
    apb_xfer(1'b0, 12'h100, 32'h0, stat);
    check("slave error", 32'h1, 32'(err_q));
    wr32(CMB_P_CTL, 32'h0e);
    // Three buffers loaded; equal lowest priority goes to the lower index.
    send(8'h00, 8'h20);
    check("buffer", 32'h0, 32'(stat[9:8]));
    check("irq flags", 32'h1, 32'(stat[4:2]));
    send(8'h40, 8'h10);
    check("buffer", 32'h1, 32'(stat[9:8]));
    send(8'h80, 8'h10);
    check("buffer", 32'h2, 32'(stat[9:8]));
    check("winner", 32'h1, 32'(tx_buf));
    check("first byte", 32'h40, 32'(tx_msg[7:0]));
    check("last byte", 32'h4c, 32'(tx_msg[103:96]));
    // Own frame is captured but neither stored nor acknowledged.
    eng(4'h8);
    check("ack enable", 32'h0, 32'(rx_ack_en));
    frame(8'h90, 1'b1, 1'b1);
    eng(4'h4);
    check("ack enable", 32'h1, 32'(rx_ack_en));
    check("winner", 32'h2, 32'(tx_buf));
    check("first byte", 32'h80, 32'(tx_msg[7:0]));
    // Error and lost arbitration leave the buffer competing.
    eng(4'h8);
    eng(4'h2);
    check("pending", 32'h1, 32'(tx_pending));
    eng(4'h8);
    eng(4'h1);
    check("ack enable", 32'h1, 32'(rx_ack_en));
    check("winner", 32'h2, 32'(tx_buf));
    eng(4'h8);
    eng(4'h4);
    check("winner", 32'h0, 32'(tx_buf));
    // Abort of the remaining buffer releases it.
    wr32(CMB_P_CMD, 32'h102);
    wait_idle();
    check("pending", 32'h0, 32'(tx_pending));
    check("abort ack", 32'h1, 32'(u_cmb_device.s.abort_ack));
    check("empty flags", 32'h7, 32'(u_cmb_device.s.tx_empty));
    recv(8'h00, 1'b1);
    // Rejected and faulty frames never enter the FIFO.
    frame(8'h01, 1'b0, 1'b1);
    frame(8'h02, 1'b1, 1'b0);
    recv(8'h00, 1'b1);
    // Six frames back to back: five stored, the sixth dropped, room reused.
    for (int k = 1; k < 7; k++) begin
      frame(8'(k * 16), 1'b1, 1'b1);
    end
    recv(8'h10, 1'b0);
    check("irq flags", 32'h7, 32'(stat[4:2]));
    frame(8'h70, 1'b1, 1'b1);
    for (int k = 2; k < 6; k++) begin
      recv(8'(k * 16), 1'b0);
    end
    recv(8'h70, 1'b0);
    recv(8'h00, 1'b1);
    check("irq flags", 32'h5, 32'(stat[4:2]));
    // Loopback with stamping: the own frame is acknowledged, stored and stamped.
    wr32(CMB_P_CTL, 32'h1f);
    send(8'ha0, 8'h05);
    eng(4'h8);
    check("ack enable", 32'h1, 32'(rx_ack_en));
    frame(8'ha0, 1'b1, 1'b1);
    eng(4'h4);
    check("abort ack", 32'h0, 32'(u_cmb_device.s.abort_ack));
    recv(8'ha0, 1'b0);
    apb_xfer(1'b0, 12'h074, 32'h0, stat);
    check("stamp high", 32'h12, stat);
    apb_xfer(1'b0, 12'h078, 32'h0, stat);
    check("stamp low", 32'h34, stat);
    conclude();
  end
endmodule
`default_nettype wire
